// ### hdl/cet_pkg.sv
// Constants, register map and types of the cascadable event timer pair.
package cet_pkg;
    localparam int          CET_CLK_HZ       = 20000000;
    localparam logic [11:0] ADDR_LOW_COUNTER  = 12'h000;
    localparam logic [11:0] ADDR_HIGH_COUNTER = 12'h004;
    localparam logic [11:0] ADDR_LOW_COMPARE  = 12'h008;
    localparam logic [11:0] ADDR_HIGH_COMPARE = 12'h00C;
    localparam logic [11:0] ADDR_CONTROL      = 12'h010;
    localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h014;
    localparam logic [11:0] ADDR_IRQ_CLEAR    = 12'h018;
    localparam logic [11:0] ADDR_IRQ_ENABLE   = 12'h01C;
    localparam int CTL_LOW_EN   = 0;
    localparam int CTL_HIGH_EN  = 1;
    localparam int CTL_OUT_EN   = 2;
    localparam int CTL_CASCADE  = 3;
    localparam int CTL_SQUARE   = 4;
    localparam int CTL_CLK_LSB  = 8;
    localparam int CTL_DIR_EVT  = 12;
    localparam int CTL_DIR_OUT  = 13;
    localparam int CTL_LATCH    = 14;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_3000;
    localparam int IRQ_LOW  = 0;
    localparam int IRQ_HIGH = 1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0]
    {
        CLK_SYS      = 3'h0,
        CLK_SYS_DIV4 = 3'h1,
        CLK_EXT      = 3'h2,
        CLK_EXT_DIV2 = 3'h3,
        CLK_EXT_DIV4 = 3'h4,
        CLK_EXT_DIV8 = 3'h5
    } cet_clk_sel_t;
    localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
    localparam logic [7:0] COUNT_ZERO    = 8'h00;
endpackage : cet_pkg

// ### hdl/cet_tick_gen.sv
// Count clock enable generator with external event synchroniser.
`timescale 1ns/1ps
module cet_tick_gen
    import cet_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Control.
    input  wire logic       run,
    input  wire logic [2:0] clockSelect,
    // Event pin.
    input  wire logic       eventInputPin,
    // Tick out.
    cet_tick_if.gen         tickBus
);
    logic [2:0] syncStage;
    logic       eventEdge;
    logic [1:0] sysDiv;
    logic [2:0] extDiv;
    logic       sysTick;
    logic [2:0] next_extDiv;
    logic       edgeSeen;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            syncStage <= 3'h0;
        else
            syncStage <= {syncStage[1:0], eventInputPin};
    end

    // Rising edge seen once stages two and three agree on the new level.
    assign eventEdge   = syncStage[1] & syncStage[2] & ~edgeSeen;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            edgeSeen <= 1'b0;
        else if (syncStage[1] == syncStage[2])
            edgeSeen <= syncStage[2]; // RULE_16
    end

    assign sysTick     = run & (sysDiv == SYS_DIV4_LAST);
    assign next_extDiv = extDiv + 3'h1;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sysDiv <= 2'h0;
        else if (!run)
            sysDiv <= 2'h0;
        else
            sysDiv <= sysDiv + 2'h1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            extDiv <= 3'h0;
        else if (!run)
            extDiv <= 3'h0;
        else if (eventEdge)
            extDiv <= next_extDiv;
    end

    // Count clock selection.
    always_comb
    begin
        unique case (clockSelect)
            CLK_SYS:      tickBus.tick = run; // RULE_14
            CLK_SYS_DIV4: tickBus.tick = sysTick;
            CLK_EXT:      tickBus.tick = run & eventEdge; // RULE_01
            CLK_EXT_DIV2: tickBus.tick = run & eventEdge & extDiv[0];
            CLK_EXT_DIV4: tickBus.tick = run & eventEdge & (&extDiv[1:0]);
            CLK_EXT_DIV8: tickBus.tick = run & eventEdge & (&extDiv);
            default:      tickBus.tick = 1'b0;
        endcase
    end

    chk_edge_once: assert property (@(posedge clk) disable iff (!reset_n)
        eventEdge |=> !eventEdge) else $error("Event edge lasted two cycles."); // RULE_16
endmodule : cet_tick_gen

// ### hdl/cet_tick_if.sv
// Count clock tick carried from the tick generator to the counters.
`timescale 1ns/1ps
interface cet_tick_if;
    logic tick;
    modport gen (output tick);
    modport use_tick (input tick);
endinterface : cet_tick_if

// ### hdl/cet_timer_pair.sv
// Top of the cascadable event timer pair with AXI4-Lite registers.
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// RULE_01: Event mode: each valid edge increments low counter.
// RULE_02: Event match clears counter, interrupts same cycle.
// RULE_03: Software stops, configures, loads, then starts event counting.
// RULE_04: Square mode match toggles pin, clears, interrupts.
// RULE_05: Low enable zero forces square output low.
// RULE_06: Output starts low when output enabled.
// RULE_07: Square period is two times compare plus one.
// RULE_08: Software configures pin and compare before starting square.
// RULE_09: Cascade: high counter upper byte, low lower.
// RULE_10: Cascade ignores high enable; low enable controls.
// RULE_11: Dual match clears both; only low interrupt.
// RULE_12: Interval is 256 high plus low plus one.
// RULE_13: Software stops both, configures, loads, then starts.
// RULE_14: Three-bit select picks system or external clocks.
// RULE_15: Software stops timer before changing clock select.
// RULE_16: Event input synchronised, one increment per edge.
module cet_timer_pair
    import cet_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset_n,
    // AXI4-Lite write address.
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [11:0] s_axi_awaddr,
    // AXI4-Lite write data.
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response.
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address.
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [11:0] s_axi_araddr,
    // AXI4-Lite read data.
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Pins.
    input  wire logic        eventInputPin,
    output logic             timerOutputPin,
    output logic             timerOutputOe,
    // Interrupt.
    output logic             irq
);
    logic [7:0]  lowCounter;
    logic [7:0]  highCounter;
    logic [7:0]  lowCompare;
    logic [7:0]  highCompare;
    logic [31:0] control;
    logic [1:0]  irqStatus;
    logic [1:0]  irqEnable;
    logic        squareLevel;
    logic        awHeld;
    logic        wHeld;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    cet_tick_if  tickBus();

    logic        lowCountEnable;
    logic        highCountEnable;
    logic        timerOutputEnable;
    logic        cascadeMode;
    logic        squareMode;
    logic        lowMatch;
    logic        highMatch;
    logic        lowClear;
    logic        highClear;
    logic        highRun;
    logic        lowIrqEvent;
    logic        highIrqEvent;
    logic        doWrite;
    logic        writeHit;
    logic        readHit;
    logic [31:0] readValue;
    logic [31:0] wMask;
    logic [31:0] next_control;
    logic [1:0]  next_irqStatus;

    assign lowCountEnable    = control[CTL_LOW_EN];
    assign highCountEnable   = control[CTL_HIGH_EN];
    assign timerOutputEnable = control[CTL_OUT_EN];
    assign cascadeMode       = control[CTL_CASCADE];
    assign squareMode        = control[CTL_SQUARE];

    cet_tick_gen u_tick
    (
        .clk           (clk),
        .reset_n       (reset_n),
        .run           (lowCountEnable),
        .clockSelect   (control[CTL_CLK_LSB +: 3]),
        .eventInputPin (eventInputPin),
        .tickBus       (tickBus.gen)
    );

    // Match and clear decode.
    assign lowMatch  = tickBus.tick & (lowCounter == lowCompare); // RULE_02
    assign highMatch = highCounter == highCompare;
    assign lowClear  = cascadeMode ? (lowMatch & highMatch) : lowMatch; // RULE_11
    assign highClear = lowClear; // RULE_11
    // High counter advances on low wrap in cascade, and never outside cascade.
    assign highRun   = cascadeMode ? (tickBus.tick & (lowCounter == 8'hFF) & ~lowClear)
                                   : 1'b0; // RULE_09
    assign lowIrqEvent  = lowClear; // RULE_02
    assign highIrqEvent = ~cascadeMode & highCountEnable & 1'b0; // RULE_11

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            lowCounter <= COUNT_ZERO;
        else if (!lowCountEnable)
            lowCounter <= COUNT_ZERO; // RULE_10
        else if (lowClear)
            lowCounter <= COUNT_ZERO; // RULE_02
        else if (tickBus.tick)
            lowCounter <= lowCounter + 8'h01; // RULE_01
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            highCounter <= COUNT_ZERO;
        else if (!lowCountEnable || !cascadeMode)
            highCounter <= COUNT_ZERO; // RULE_10
        else if (tickBus.tick && highClear)
            highCounter <= COUNT_ZERO; // RULE_12
        else if (highRun)
            highCounter <= highCounter + 8'h01; // RULE_09
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            squareLevel <= 1'b0;
        else if (!lowCountEnable || !timerOutputEnable)
            squareLevel <= 1'b0; // RULE_05
        else if (squareMode && lowClear)
            squareLevel <= ~squareLevel; // RULE_04 RULE_07
    end

    assign timerOutputPin = squareLevel & timerOutputEnable & ~control[CTL_DIR_OUT]; // RULE_06
    assign timerOutputOe  = ~control[CTL_DIR_OUT];

    // AXI4-Lite slave.
    assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
    assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign doWrite       = awHeld & wHeld & ~s_axi_bvalid;
    assign wMask         = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
    assign next_control  = (control & ~wMask) | (wData & wMask);
    assign writeHit      = (awAddr == ADDR_LOW_COMPARE) || (awAddr == ADDR_HIGH_COMPARE)
                        || (awAddr == ADDR_CONTROL) || (awAddr == ADDR_IRQ_CLEAR)
                        || (awAddr == ADDR_IRQ_ENABLE);
    assign readHit       = (s_axi_araddr[11:5] == 7'h00) && (s_axi_araddr[4:0] != 5'h18)
                        && (s_axi_araddr[1:0] == 2'h0);
    assign next_irqStatus = {highIrqEvent, lowIrqEvent}
                         | (irqStatus & ~((doWrite && awAddr == ADDR_IRQ_CLEAR && wStrb[0])
                                          ? wData[1:0] : 2'h0));
    assign irq           = |(irqStatus & irqEnable);

    always_comb
    begin
        unique case (s_axi_araddr)
            ADDR_LOW_COUNTER:  readValue = {24'h0, lowCounter};
            ADDR_HIGH_COUNTER: readValue = {24'h0, highCounter};
            ADDR_LOW_COMPARE:  readValue = {24'h0, lowCompare};
            ADDR_HIGH_COMPARE: readValue = {24'h0, highCompare};
            ADDR_CONTROL:      readValue = control;
            ADDR_IRQ_STATUS:   readValue = {30'h0, irqStatus};
            ADDR_IRQ_ENABLE:   readValue = {30'h0, irqEnable};
            default:           readValue = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            awAddr <= 12'h0;
            wData  <= 32'h0;
            wStrb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            else if (doWrite)
                awHeld <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            else if (doWrite)
                wHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= writeHit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lowCompare  <= COUNT_ZERO;
            highCompare <= COUNT_ZERO;
            control     <= CONTROL_RESET;
            irqEnable   <= 2'h0;
        end
        else if (doWrite && wStrb[0])
        begin
            if (awAddr == ADDR_LOW_COMPARE)
                lowCompare <= wData[7:0];
            if (awAddr == ADDR_HIGH_COMPARE)
                highCompare <= wData[7:0];
            if (awAddr == ADDR_IRQ_ENABLE)
                irqEnable <= wData[1:0];
            if (awAddr == ADDR_CONTROL)
                control <= next_control;
        end
        else if (doWrite && awAddr == ADDR_CONTROL)
            control <= next_control;
    end

    // Set wins over clear.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irqStatus <= 2'h0;
        else
            irqStatus <= next_irqStatus;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= readValue;
            s_axi_rresp  <= readHit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    chk_match_clears: assert property (@(posedge clk) disable iff (!reset_n)
        lowClear && lowCountEnable |=> lowCounter == COUNT_ZERO)
        else $error("Counter not cleared after match."); // RULE_02
    chk_match_irq: assert property (@(posedge clk) disable iff (!reset_n)
        lowClear && lowCountEnable |=> irqStatus[IRQ_LOW])
        else $error("Match without low interrupt."); // RULE_02
    chk_square_toggle: assert property (@(posedge clk) disable iff (!reset_n)
        lowClear && squareMode && lowCountEnable && timerOutputEnable
        |=> squareLevel != $past(squareLevel))
        else $error("Square output did not toggle."); // RULE_04
    chk_stop_low: assert property (@(posedge clk) disable iff (!reset_n)
        !lowCountEnable |=> !squareLevel)
        else $error("Square output not forced low."); // RULE_05
    chk_no_high_irq: assert property (@(posedge clk) disable iff (!reset_n)
        cascadeMode |-> !highIrqEvent)
        else $error("High interrupt in cascade mode."); // RULE_11
    chk_cascade_pair: assert property (@(posedge clk) disable iff (!reset_n)
        lowCountEnable && cascadeMode && tickBus.tick && lowCounter == 8'hFF && !lowClear
        |=> highCounter == $past(highCounter) + 8'h01)
        else $error("High byte missed carry."); // RULE_09
    chk_high_ignored: assert property (@(posedge clk) disable iff (!reset_n)
        !lowCountEnable |=> highCounter == COUNT_ZERO && lowCounter == COUNT_ZERO)
        else $error("Counters run without low enable."); // RULE_10
    chk_partial_keep: assert property (@(posedge clk) disable iff (!reset_n)
        cascadeMode && lowMatch && !highMatch && lowCountEnable && lowCounter != 8'hFF
        |=> lowCounter == $past(lowCounter) + 8'h01)
        else $error("Low cleared without high match."); // RULE_12
    cov_event_match: cover property (@(posedge clk) disable iff (!reset_n)
        lowClear && !cascadeMode && !squareMode);
    cov_square_toggle: cover property (@(posedge clk) disable iff (!reset_n)
        lowClear && squareMode && timerOutputEnable);
    cov_cascade_match: cover property (@(posedge clk) disable iff (!reset_n)
        lowClear && cascadeMode);
endmodule : cet_timer_pair

// ### testbench/cet_pin_partner.sv
// External pulse source and timer output pin load.
`timescale 1ns/1ps
module cet_pin_partner
(
    // Clock.
    input  wire logic clk,
    // Pins.
    output logic      eventInputPin,
    input  wire logic timerOutputPin,
    input  wire logic timerOutputOe,
    // Level seen by the load.
    output logic      pinLevel
);
    // The load pulls the pin high while the block leaves it undriven.
    assign pinLevel = timerOutputOe ? timerOutputPin : 1'b1;
    initial eventInputPin = 1'b0;
    // Sends pulses that stay high and low for three clocks each.
    task automatic send(input int n);
        for (int i = 0; i < n; i++)
        begin
            repeat (3) @(posedge clk);
            eventInputPin <= ~eventInputPin;
            repeat (3) @(posedge clk);
            eventInputPin <= ~eventInputPin;
        end
        repeat (8) @(posedge clk);
    endtask : send
endmodule : cet_pin_partner

// ### testbench/cet_timer_pair_tb_top.sv
// Testbench of the cascadable event timer pair.
`timescale 1ns/1ps
module cet_timer_pair_tb_top;
    import cet_pkg::*;
    logic        clk = 1'b0;
    logic        resetN = 1'b0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        eventInputPin, timerOutputPin, timerOutputOe, irq, pinLevel;
    logic [2:0]  sqSel [4] = '{3'h0, 3'h1, 3'h0, 3'h0};
    logic [7:0]  sqCmp [4] = '{8'h03, 8'h03, 8'hFF, 8'h00};
    int          cycleNum = 0;
    int          errTotal = 0;
    int          nTests = 0;
    int          t1, t2;

    always #25 clk = ~clk;
    always @(posedge clk) cycleNum <= cycleNum + 1;

    cet_timer_pair u_cet_timer_pair (.clk, .reset_n(resetN), .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .eventInputPin,
        .timerOutputPin, .timerOutputOe, .irq);
    cet_pin_partner u_cet_pin_partner (.clk, .eventInputPin, .timerOutputPin, .timerOutputOe,
        .pinLevel);

    task automatic endSim;
        $display("checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : endSim

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp)
        begin
            errTotal++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic timeOut(input string what);
        errTotal++;
        $display("unexpected wait %s: expected answer seen none", what);
        endSim();
    endtask : timeOut

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er,
                      input logic [3:0] st = 4'hF);
        int n;
        @(posedge clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            s_axi_awvalid <= s_axi_awvalid && (s_axi_awready !== 1'b1);
            s_axi_wvalid  <= s_axi_wvalid && (s_axi_wready !== 1'b1);
            if (s_axi_bvalid === 1'b1)
                break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50)
            timeOut("write");
        check("bresp", 32'(er), 32'(s_axi_bresp));
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            s_axi_arvalid <= s_axi_arvalid && (s_axi_arready !== 1'b1);
            if (s_axi_rvalid === 1'b1)
                break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50)
            timeOut("read");
        check("rresp", 32'(er), 32'(s_axi_rresp));
        check($sformatf("rdata %0h", a), exp, s_axi_rdata);
    endtask : rd

    task automatic waitRise(input logic useIrq, output int t);
        logic p, c;
        int n;
        p = useIrq ? irq : pinLevel;
        for (n = 0; n < 3000; n++)
        begin
            @(negedge clk);
            c = useIrq ? irq : pinLevel;
            if (c && !p)
                break;
            p = c;
        end
        t = cycleNum;
        if (n == 3000)
            timeOut("rise");
    endtask : waitRise

    // Control word with the event pin as input; square mode drives the output pin.
    function automatic logic [31:0] ctl(input logic en, input logic [2:0] sel,
                                        input logic casc, input logic sq);
        logic [31:0] v;
        v = 32'h0000_1000;
        v[CTL_LOW_EN] = en;
        v[CTL_CASCADE] = casc;
        v[CTL_SQUARE] = sq;
        v[CTL_OUT_EN] = sq;
        v[CTL_DIR_OUT] = !sq;
        v[CTL_CLK_LSB +: 3] = sel;
        return v;
    endfunction : ctl

    initial
    begin
        repeat (3) @(posedge clk);
        resetN <= 1'b1;
        rd(ADDR_CONTROL, CONTROL_RESET, RESP_OKAY);
        rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
        rd(ADDR_IRQ_CLEAR, 32'h0, RESP_SLVERR);
        rd(12'h020, 32'h0, RESP_SLVERR);
        wr(ADDR_LOW_COUNTER, 32'h1, RESP_SLVERR);
        check("oe", 32'h0, 32'(timerOutputOe));
        wr(ADDR_LOW_COMPARE, 32'h5A, RESP_OKAY, 4'hE);
        rd(ADDR_LOW_COMPARE, 32'h0, RESP_OKAY);
        wr(ADDR_CONTROL, 32'h0000_0004, RESP_OKAY, 4'h1);
        rd(ADDR_CONTROL, CONTROL_RESET | 32'h0000_0004, RESP_OKAY);
        $display("test registers done");
        wr(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
        wr(ADDR_CONTROL, ctl(1'b0, CLK_EXT, 1'b0, 1'b0), RESP_OKAY);
        wr(ADDR_LOW_COMPARE, 32'h4, RESP_OKAY);
        wr(ADDR_CONTROL, ctl(1'b1, CLK_EXT, 1'b0, 1'b0), RESP_OKAY);
        u_cet_pin_partner.send(3);
        rd(ADDR_LOW_COUNTER, 32'h3, RESP_OKAY);
        u_cet_pin_partner.send(1);
        rd(ADDR_LOW_COUNTER, 32'h4, RESP_OKAY);
        check("irq", 32'h0, 32'(irq));
        u_cet_pin_partner.send(1);
        rd(ADDR_LOW_COUNTER, 32'h0, RESP_OKAY);
        rd(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
        check("irq", 32'h1, 32'(irq));
        wr(ADDR_IRQ_ENABLE, 32'h0, RESP_OKAY);
        check("masked irq", 32'h0, 32'(irq));
        wr(ADDR_IRQ_CLEAR, 32'h1, RESP_OKAY);
        rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
        wr(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
        $display("test event counter done");
        for (int s = 3; s <= 5; s++)
        begin
            wr(ADDR_CONTROL, ctl(1'b0, 3'(s - 1), 1'b0, 1'b0), RESP_OKAY);
            wr(ADDR_LOW_COMPARE, 32'hFF, RESP_OKAY);
            wr(ADDR_CONTROL, ctl(1'b0, 3'(s), 1'b0, 1'b0), RESP_OKAY);
            wr(ADDR_CONTROL, ctl(1'b1, 3'(s), 1'b0, 1'b0), RESP_OKAY);
            u_cet_pin_partner.send(3 << (s - 2));
            rd(ADDR_LOW_COUNTER, 32'h3, RESP_OKAY);
        end
        wr(ADDR_CONTROL, ctl(1'b0, CLK_EXT_DIV8, 1'b0, 1'b0), RESP_OKAY);
        $display("test dividers done");
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_CONTROL, ctl(1'b0, sqSel[i], 1'b0, 1'b1), RESP_OKAY);
            check("start level", 32'h0, 32'(pinLevel));
            check("oe", 32'h1, 32'(timerOutputOe));
            wr(ADDR_LOW_COMPARE, 32'(sqCmp[i]), RESP_OKAY);
            wr(ADDR_CONTROL, ctl(1'b1, sqSel[i], 1'b0, 1'b1), RESP_OKAY);
            waitRise(1'b0, t1);
            waitRise(1'b0, t2);
            check("period", 32'(2 * (sqCmp[i] + 1) * (sqSel[i] == CLK_SYS_DIV4 ? 4 : 1)),
                  32'(t2 - t1));
            rd(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
            wr(ADDR_CONTROL, ctl(1'b0, sqSel[i], 1'b0, 1'b1), RESP_OKAY);
            @(negedge clk);
            check("stopped level", 32'h0, 32'(pinLevel));
        end
        $display("test square wave done");
        wr(ADDR_CONTROL, ctl(1'b0, CLK_EXT, 1'b1, 1'b0) | 32'h2, RESP_OKAY);
        wr(ADDR_HIGH_COMPARE, 32'h1, RESP_OKAY);
        wr(ADDR_LOW_COMPARE, 32'h2, RESP_OKAY);
        u_cet_pin_partner.send(2);
        rd(ADDR_LOW_COUNTER, 32'h0, RESP_OKAY);
        wr(ADDR_CONTROL, ctl(1'b1, CLK_EXT, 1'b1, 1'b0) | 32'h2, RESP_OKAY);
        wr(ADDR_IRQ_CLEAR, 32'h3, RESP_OKAY);
        u_cet_pin_partner.send(3);
        rd(ADDR_LOW_COUNTER, 32'h3, RESP_OKAY);
        u_cet_pin_partner.send(254);
        rd(ADDR_HIGH_COUNTER, 32'h1, RESP_OKAY);
        rd(ADDR_LOW_COUNTER, 32'h1, RESP_OKAY);
        u_cet_pin_partner.send(1);
        rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
        u_cet_pin_partner.send(1);
        rd(ADDR_HIGH_COUNTER, 32'h0, RESP_OKAY);
        rd(ADDR_LOW_COUNTER, 32'h0, RESP_OKAY);
        rd(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
        $display("test cascade events done");
        wr(ADDR_CONTROL, ctl(1'b0, CLK_EXT, 1'b1, 1'b0), RESP_OKAY);
        wr(ADDR_CONTROL, ctl(1'b0, CLK_SYS, 1'b1, 1'b0), RESP_OKAY);
        wr(ADDR_IRQ_CLEAR, 32'h3, RESP_OKAY);
        wr(ADDR_CONTROL, ctl(1'b1, CLK_SYS, 1'b1, 1'b0), RESP_OKAY);
        waitRise(1'b1, t1);
        wr(ADDR_IRQ_CLEAR, 32'h1, RESP_OKAY);
        waitRise(1'b1, t2);
        check("interval", 32'd259, 32'(t2 - t1));
        $display("test cascade interval done");
        @(posedge clk);
        resetN <= 1'b0;
        repeat (3) @(posedge clk);
        resetN <= 1'b1;
        check("reset irq", 32'h0, 32'(irq));
        check("reset oe", 32'h0, 32'(timerOutputOe));
        rd(ADDR_LOW_COUNTER, 32'h0, RESP_OKAY);
        rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
        rd(ADDR_CONTROL, CONTROL_RESET, RESP_OKAY);
        $display("test reset done");
        endSim();
    end
endmodule : cet_timer_pair_tb_top
